// file: kae_defs.vh
// Purpose: Shared constants for the keyboard and answerback encoder
// Assumes: 100 MHz mclk, 32-bit classic Wishbone register access
// Notes: Register offsets are byte addresses
`ifndef KAE_DEFS_VH
`define KAE_DEFS_VH

// Timing
`define KAE_CLK_NS 10
`define KAE_STROBE_NS 100
`define KAE_STROBE_W 8

// Character set
`define KAE_CHAR_W 7
`define KAE_CODE_BASE 7'h20
`define KAE_CODE_DEL 7'h7F
`define KAE_CODE_CR 7'h0D
`define KAE_CODE_LF 7'h0A
`define KAE_CODE_ESC 7'h1B
`define KAE_FUNC_BASE 7'h41
`define KAE_LETTER_LO 7'h41
`define KAE_LETTER_HI 7'h5A
`define KAE_DIGIT_LO 7'h30
`define KAE_CASE_BIT 7'h20
`define KAE_SHIFT_PAIR_BIT 7'h10
`define KAE_CTRL_MASK 7'h1F

// Answerback store
`define KAE_AB_DEPTH 20
`define KAE_AB_IDX_W 5

// Register map
`define KAE_ADR_W 8
`define KAE_REG_CTRL 8'h00
`define KAE_REG_STATUS 8'h04
`define KAE_REG_TRIG 8'h08
`define KAE_REG_AB_BASE 8'h40
`define KAE_REG_AB_LAST 8'h8C

// Control fields
`define KAE_CTRL_AUTO_NL 0
`define KAE_CTRL_UC_LOCK 1
`define KAE_CTRL_STOP_LAST 2
`define KAE_CTRL_LAST_LO 8
`define KAE_CTRL_LAST_HI 12
`define KAE_TRIG_START 0

// Status fields
`define KAE_ST_AB_BUSY 0
`define KAE_ST_LOCKOUT 1
`define KAE_ST_MULTI 2
`define KAE_ST_SEND_BUSY 3
`define KAE_ST_CODE_LO 8
`define KAE_ST_CODE_HI 14

`endif

// file: kae_answerback.v
// Purpose: Answerback store and sequencer
// Assumes: take pulses once for each character accepted downstream
// Notes: Store is written by software; lockout lasts the whole sequence
`timescale 1ns/1ps
`include "kae_defs.vh"

module kae_answerback #(
    parameter DEPTH = `KAE_AB_DEPTH,
    parameter IDX_W = `KAE_AB_IDX_W,
    parameter CHAR_W = `KAE_CHAR_W
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Control
    input wire trigger,
    input wire stopAtLast,
    input wire [IDX_W-1:0] lastIndex,
    // Store access
    input wire wrEn,
    input wire [IDX_W-1:0] wrIdx,
    input wire [CHAR_W-1:0] wrData,
    input wire [IDX_W-1:0] rdIdx,
    output wire [CHAR_W-1:0] rdData,
    // Character stream
    input wire take,
    output wire [CHAR_W-1:0] charOut,
    output wire charValid,
    output reg kbdLockout
);

reg [CHAR_W-1:0] store [0:DEPTH-1];
reg [IDX_W-1:0] pos;
wire [IDX_W-1:0] endIdx;
integer i;

localparam [IDX_W-1:0] FULL_LAST = DEPTH - 1;

////////////////////////////////////////////////////////////////////////////////

// A last index past the store falls back to the full length
assign endIdx = (stopAtLast && lastIndex < FULL_LAST) ? lastIndex : FULL_LAST;
assign charOut = store[pos];
assign charValid = kbdLockout;
assign rdData = (rdIdx < FULL_LAST || rdIdx == FULL_LAST) ? store[rdIdx] : {CHAR_W{1'b0}};

always @(posedge mclk)
begin
    if (!reset_n)
    begin
        for (i = 0; i < DEPTH; i = i + 1)
            store[i] <= {CHAR_W{1'b0}};
    end
    else if (wrEn && (wrIdx < FULL_LAST || wrIdx == FULL_LAST))
    begin
        store[wrIdx] <= wrData;
    end
end

always @(posedge mclk)
begin
    if (!reset_n)
    begin
        kbdLockout <= 1'b0;
        pos <= {IDX_W{1'b0}};
    end
    else if (!kbdLockout)
    begin
        if (trigger)
        begin
            kbdLockout <= 1'b1;
            pos <= {IDX_W{1'b0}};
        end
    end
    else if (take)
    begin
        if (pos == endIdx)
            kbdLockout <= 1'b0;
        else
            pos <= pos + 1'b1;
    end
end

endmodule // kae_answerback

// file: kae_keyboard_encoder.v
// Purpose: Keyboard encoder and answerback source toward the serializer
// Assumes: Key and photocell inputs already synchronous to mclk
// Notes: One character at a time; key events are dropped while a key character is pending or under lockout or interrupt
`timescale 1ns/1ps
`include "kae_defs.vh"

module kae_keyboard_encoder #(
    parameter KEYS = 64,
    parameter FUNCS = 4,
    parameter CHAR_W = `KAE_CHAR_W
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`KAE_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Keyboard
    input wire [KEYS-1:0] keyLines,
    input wire returnKey,
    input wire deleteKey,
    input wire [FUNCS-1:0] funcKeys,
    input wire shiftKey,
    input wire controlKey,
    input wire repeatKey,
    input wire refFingerPass,
    input wire interruptCond,
    // Answerback triggers
    input wire answerbackButton,
    input wire enquiryRx,
    input wire delayedEnquiryFlag,
    input wire ringDetect,
    // Serializer side
    output reg [CHAR_W-1:0] charCode,
    output reg charStrobe,
    output wire kbdLockout
);

localparam ALL_W = KEYS + FUNCS + 2;
localparam [`KAE_STROBE_W-1:0] STROBE_CYC = (`KAE_STROBE_NS + `KAE_CLK_NS - 1) / `KAE_CLK_NS;
localparam [`KAE_AB_IDX_W-1:0] AB_LAST_IDX = `KAE_AB_DEPTH - 1;
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_STROBE = 2'h1;
localparam [1:0] ST_GAP = 2'h2;

// Registers
reg autoNewline;
reg upperCaseLock;
reg stopAtLast;
reg [`KAE_AB_IDX_W-1:0] lastIndex;
reg swTrigger;
reg abWrEn;
reg [`KAE_AB_IDX_W-1:0] abWrIdx;
reg [CHAR_W-1:0] abWrData;

// Sequencer
reg [1:0] state;
reg [`KAE_STROBE_W-1:0] strobeCnt;
reg fromAb;
reg abTake;
reg [CHAR_W-1:0] pendFirst;
reg [CHAR_W-1:0] pendSecond;
reg [1:0] pendCount;
reg prevSingle;
reg prevRef;
reg prevTrigSrc;

// Encoder
wire [ALL_W-1:0] allKeys;
wire anyKey;
wire multiKey;
wire singleKey;
wire refRise;
wire inhibit;
wire keyNew;
wire repeatFire;
wire trigSrc;
wire abTrigger;
wire [CHAR_W-1:0] abChar;
wire abValid;
wire [CHAR_W-1:0] abRdData;
wire [`KAE_AB_IDX_W-1:0] abRdIdx;
wire [`KAE_ADR_W-1:0] abOffset;
wire abHit;
reg [CHAR_W-1:0] firstCode;
reg [CHAR_W-1:0] secondCode;
reg hasSecond;
reg [CHAR_W-1:0] baseCode;
reg [CHAR_W-1:0] keyIdx;
reg [CHAR_W-1:0] funcIdx;
reg isLetter;
integer k;

////////////////////////////////////////////////////////////////////////////////
// Key sensing

assign allKeys = {funcKeys, deleteKey, returnKey, keyLines};
assign anyKey = |allKeys;
assign multiKey = |(allKeys & (allKeys - 1'b1));
assign singleKey = anyKey && !multiKey;
assign refRise = refFingerPass && !prevRef;
assign inhibit = kbdLockout || interruptCond;
assign keyNew = singleKey && !prevSingle;
assign repeatFire = singleKey && repeatKey && refRise;

always @*
begin
    keyIdx = {CHAR_W{1'b0}};
    funcIdx = {CHAR_W{1'b0}};
    for (k = 0; k < KEYS; k = k + 1)
        if (keyLines[k])
            keyIdx = k[CHAR_W-1:0];
    for (k = 0; k < FUNCS; k = k + 1)
        if (funcKeys[k])
            funcIdx = k[CHAR_W-1:0];
    baseCode = `KAE_CODE_BASE + keyIdx;
    isLetter = baseCode >= `KAE_LETTER_LO && baseCode <= `KAE_LETTER_HI;
    firstCode = baseCode;
    secondCode = {CHAR_W{1'b0}};
    hasSecond = 1'b0;
    if (deleteKey)
    begin
        firstCode = `KAE_CODE_DEL;
    end
    else if (returnKey)
    begin
        firstCode = `KAE_CODE_CR;
        secondCode = `KAE_CODE_LF;
        hasSecond = autoNewline;
    end
    else if (|funcKeys)
    begin
        firstCode = `KAE_CODE_ESC;
        secondCode = `KAE_FUNC_BASE + funcIdx;
        hasSecond = 1'b1;
    end
    else
    begin
        if (isLetter && !shiftKey && !upperCaseLock)
            firstCode = baseCode | `KAE_CASE_BIT;
        else if (!isLetter && shiftKey && baseCode >= `KAE_DIGIT_LO)
            firstCode = baseCode ^ `KAE_SHIFT_PAIR_BIT;
        if (controlKey)
            firstCode = firstCode & `KAE_CTRL_MASK;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Answerback

assign trigSrc = answerbackButton || enquiryRx || delayedEnquiryFlag || ringDetect;
assign abTrigger = (trigSrc && !prevTrigSrc) || swTrigger;
assign abOffset = wb_adr_i - `KAE_REG_AB_BASE;
assign abHit = wb_adr_i >= `KAE_REG_AB_BASE && wb_adr_i <= `KAE_REG_AB_LAST;
assign abRdIdx = abOffset[`KAE_AB_IDX_W+1:2];

kae_answerback #(
    .DEPTH(`KAE_AB_DEPTH),
    .IDX_W(`KAE_AB_IDX_W),
    .CHAR_W(CHAR_W)
) uAnswerback (
    .mclk(mclk),
    .reset_n(reset_n),
    .trigger(abTrigger),
    .stopAtLast(stopAtLast),
    .lastIndex(lastIndex),
    .wrEn(abWrEn),
    .wrIdx(abWrIdx),
    .wrData(abWrData),
    .rdIdx(abRdIdx),
    .rdData(abRdData),
    .take(abTake),
    .charOut(abChar),
    .charValid(abValid),
    .kbdLockout(kbdLockout)
);

////////////////////////////////////////////////////////////////////////////////
// Output sequencer

always @(posedge mclk)
begin
    if (!reset_n)
    begin
        state <= ST_IDLE;
        strobeCnt <= {`KAE_STROBE_W{1'b0}};
        fromAb <= 1'b0;
        abTake <= 1'b0;
        charCode <= {CHAR_W{1'b0}};
        charStrobe <= 1'b0;
        pendFirst <= {CHAR_W{1'b0}};
        pendSecond <= {CHAR_W{1'b0}};
        pendCount <= 2'h0;
        prevSingle <= 1'b0;
        prevRef <= 1'b0;
        prevTrigSrc <= 1'b0;
    end
    else
    begin
        prevSingle <= singleKey;
        prevRef <= refFingerPass;
        prevTrigSrc <= trigSrc;
        abTake <= 1'b0;
        // Pending key characters die under lockout so nothing leaks after it
        if (inhibit)
        begin
            pendCount <= 2'h0;
        end
        else if (pendCount == 2'h0 && (keyNew || repeatFire))
        begin
            pendFirst <= firstCode;
            pendSecond <= secondCode;
            pendCount <= hasSecond ? 2'h2 : 2'h1;
        end
        case (state)
            ST_IDLE:
            begin
                if (abValid)
                begin
                    charCode <= abChar;
                    charStrobe <= 1'b1;
                    fromAb <= 1'b1;
                    strobeCnt <= STROBE_CYC;
                    state <= ST_STROBE;
                end
                else if (pendCount != 2'h0 && !inhibit)
                begin
                    charCode <= pendFirst;
                    charStrobe <= 1'b1;
                    fromAb <= 1'b0;
                    strobeCnt <= STROBE_CYC;
                    state <= ST_STROBE;
                    pendFirst <= pendSecond;
                    pendCount <= pendCount - 1'b1;
                end
            end
            ST_STROBE:
            begin
                // Code register is not loaded here, so it holds for the strobe
                if (strobeCnt == 1'b1)
                begin
                    charStrobe <= 1'b0;
                    abTake <= fromAb;
                    state <= ST_GAP;
                end
                else
                begin
                    strobeCnt <= strobeCnt - 1'b1;
                end
            end
            ST_GAP:
            begin
                state <= ST_IDLE;
            end
            default:
            begin
                charStrobe <= 1'b0;
                state <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Wishbone slave: one wait state, unmapped reads return zero

always @(posedge mclk)
begin
    if (!reset_n)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        autoNewline <= 1'b0;
        upperCaseLock <= 1'b0;
        stopAtLast <= 1'b0;
        lastIndex <= AB_LAST_IDX;
        swTrigger <= 1'b0;
        abWrEn <= 1'b0;
        abWrIdx <= {`KAE_AB_IDX_W{1'b0}};
        abWrData <= {CHAR_W{1'b0}};
    end
    else
    begin
        wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        swTrigger <= 1'b0;
        abWrEn <= 1'b0;
        wb_dat_o <= 32'h00000000;
        if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        begin
            if (wb_we_i)
            begin
                if (wb_adr_i == `KAE_REG_CTRL)
                begin
                    if (wb_sel_i[0])
                    begin
                        autoNewline <= wb_dat_i[`KAE_CTRL_AUTO_NL];
                        upperCaseLock <= wb_dat_i[`KAE_CTRL_UC_LOCK];
                        stopAtLast <= wb_dat_i[`KAE_CTRL_STOP_LAST];
                    end
                    if (wb_sel_i[1])
                        lastIndex <= wb_dat_i[`KAE_CTRL_LAST_HI:`KAE_CTRL_LAST_LO];
                end
                else if (wb_adr_i == `KAE_REG_TRIG && wb_sel_i[0])
                begin
                    swTrigger <= wb_dat_i[`KAE_TRIG_START];
                end
                else if (abHit && wb_sel_i[0])
                begin
                    abWrEn <= 1'b1;
                    abWrIdx <= abRdIdx;
                    abWrData <= wb_dat_i[CHAR_W-1:0];
                end
            end
            else if (wb_adr_i == `KAE_REG_CTRL)
            begin
                wb_dat_o[`KAE_CTRL_AUTO_NL] <= autoNewline;
                wb_dat_o[`KAE_CTRL_UC_LOCK] <= upperCaseLock;
                wb_dat_o[`KAE_CTRL_STOP_LAST] <= stopAtLast;
                wb_dat_o[`KAE_CTRL_LAST_HI:`KAE_CTRL_LAST_LO] <= lastIndex;
            end
            else if (wb_adr_i == `KAE_REG_STATUS)
            begin
                wb_dat_o[`KAE_ST_AB_BUSY] <= abValid;
                wb_dat_o[`KAE_ST_LOCKOUT] <= inhibit;
                wb_dat_o[`KAE_ST_MULTI] <= multiKey;
                wb_dat_o[`KAE_ST_SEND_BUSY] <= state != ST_IDLE;
                wb_dat_o[`KAE_ST_CODE_HI:`KAE_ST_CODE_LO] <= charCode;
            end
            else if (abHit)
            begin
                wb_dat_o[CHAR_W-1:0] <= abRdData;
            end
        end
    end
end

endmodule // kae_keyboard_encoder

// file: kae_keyboard_encoder_sva.sv
// Purpose: Port checker for the keyboard and answerback encoder
// Assumes: One clock, synchronous active-low reset
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ps
module kae_keyboard_encoder_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Character link
    input wire logic interruptCond,
    input wire logic [6:0] charCode,
    input wire logic charStrobe,
    input wire logic kbdLockout
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    strobe_len_a: assert property (
        $rose(charStrobe) |-> charStrobe [*8] ##1 charStrobe [*2] ##1 !charStrobe)
        else $error("character strobe length wrong");
    strobe_gap_a: assert property (
        $fell(charStrobe) |=> !charStrobe)
        else $error("character strobe gap too short");
    code_hold_a: assert property (
        charStrobe && $past(charStrobe) |-> $stable(charCode))
        else $error("character code moved under strobe");
    int_quiet_a: assert property (
        interruptCond && $past(interruptCond) && $past(interruptCond, 2) && !kbdLockout |-> !$rose(charStrobe))
        else $error("keyboard character during interrupt");
    lock_start_a: assert property (
        $rose(kbdLockout) |=> $rose(charStrobe))
        else $error("answerback did not follow lockout");
    lock_end_a: assert property (
        $fell(kbdLockout) |-> !charStrobe && !$past(charStrobe))
        else $error("lockout released under a strobe");
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    ack_time_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    dat_idle_a: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
endmodule // kae_keyboard_encoder_sva

bind kae_keyboard_encoder kae_keyboard_encoder_sva chk (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .interruptCond(interruptCond),
    .charCode(charCode), .charStrobe(charStrobe), .kbdLockout(kbdLockout));

// file: kae_serializer_model.sv
// Purpose: Serializer stand-in that collects characters
// Assumes: One character per strobe rise
// Notes: Passive; the encoder has no back-pressure input
`timescale 1ns/1ps
module kae_serializer_model (
    // Clock
    input wire logic mclk,
    // Character link
    input wire logic [6:0] charCode,
    input wire logic charStrobe
);
    logic [6:0] got[$];
    logic prevStrobe = 1'b0;
    always @(posedge mclk)
    begin
        if (charStrobe && !prevStrobe)
            got.push_back(charCode);
        prevStrobe <= charStrobe;
    end
endmodule // kae_serializer_model

// file: kae_keyboard_encoder_bench.sv
// Purpose: Self-checking bench for the keyboard and answerback encoder
// Assumes: Serializer model collects every strobed character
// Notes: Expected characters are queued by a model and compared in order
`timescale 1ns/1ps
`include "kae_defs.vh"
module kae_keyboard_encoder_bench;
    logic mclk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, charStrobe, kbdLockout, returnKey = 0, deleteKey = 0, shiftKey = 0, controlKey = 0;
    logic [63:0] keyLines = 64'h0;
    logic [3:0] funcKeys = 4'h0;
    logic repeatKey = 0, refFingerPass = 0, interruptCond = 0, answerbackButton = 0, enquiryRx = 0;
    logic delayedEnquiryFlag = 0, ringDetect = 0;
    logic [6:0] charCode, expq[$], ab[20];
    int mismatches = 0, nChecks = 0, seed, k, n;
    logic sh, ct, lk;
    always #5 mclk = ~mclk;
    kae_keyboard_encoder dut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .keyLines(keyLines), .returnKey(returnKey), .deleteKey(deleteKey),
        .funcKeys(funcKeys), .shiftKey(shiftKey), .controlKey(controlKey), .repeatKey(repeatKey),
        .refFingerPass(refFingerPass), .interruptCond(interruptCond), .answerbackButton(answerbackButton),
        .enquiryRx(enquiryRx), .delayedEnquiryFlag(delayedEnquiryFlag), .ringDetect(ringDetect),
        .charCode(charCode), .charStrobe(charStrobe), .kbdLockout(kbdLockout));
    kae_serializer_model ser (.mclk(mclk), .charCode(charCode), .charStrobe(charStrobe));
    ////////////////////////////////////////////////////////////////
    task automatic finalReport;
        $display("checks=%0d mismatches=%0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmpWord(input logic [31:0] g, input logic [31:0] e);
        nChecks++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmpChar(input logic [6:0] g, input logic [6:0] e);
        nChecks++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bus cycle held until the edge that samples ack; bounded wait
    task automatic wbXfer(input logic [7:0] a, input logic we, input logic [31:0] d);
        int i;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (i = 0; i < 50; i++)
        begin
            @(posedge mclk);
            if (wb_ack_o === 1'b1)
                break;
        end
        if (i == 50)
        begin
            mismatches++;
            finalReport;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic key(input logic [63:0] kl, input logic rk, input logic dk, input logic [3:0] fk);
        @(posedge mclk);
        keyLines <= kl;
        returnKey <= rk;
        deleteKey <= dk;
        funcKeys <= fk;
        repeat (4) @(posedge mclk);
        keyLines <= 64'h0;
        returnKey <= 1'b0;
        deleteKey <= 1'b0;
        funcKeys <= 4'h0;
    endtask
    // Quiet means no strobe and no lockout for 30 cycles
    task automatic drain;
        int q, i;
        q = 0;
        for (i = 0; i < 4000 && q < 30; i++)
        begin
            @(posedge mclk);
            q = (charStrobe !== 1'b0 || kbdLockout !== 1'b0) ? 0 : q + 1;
        end
        if (q < 30)
        begin
            mismatches++;
            finalReport;
        end
        cmpWord(32'(ser.got.size()), 32'(expq.size()));
        while (expq.size() > 0 && ser.got.size() > 0)
            cmpChar(ser.got.pop_front(), expq.pop_front());
        expq.delete();
        ser.got.delete();
    endtask
    function automatic logic [6:0] keyCode(input int kk, input logic s, input logic c, input logic l);
        logic [6:0] v;
        v = `KAE_CODE_BASE + 7'(kk);
        if (v >= `KAE_LETTER_LO && v <= `KAE_LETTER_HI)
            v = (s || l) ? v : (v | `KAE_CASE_BIT);
        else if (s && v >= `KAE_DIGIT_LO)
            v = v ^ `KAE_SHIFT_PAIR_BIT;
        return c ? (v & `KAE_CTRL_MASK) : v;
    endfunction
    ////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h9052;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        wbXfer(`KAE_REG_CTRL, 0, 0);
        cmpWord(rd, 32'h0000_1300);
        wbXfer(8'h10, 0, 0);
        cmpWord(rd, 32'h0);
        for (n = 0; n < 24; n++)
        begin
            k = $unsigned($random(seed)) % 64;
            {sh, ct, lk} = 3'($random(seed));
            wbXfer(`KAE_REG_CTRL, 1, {30'h0, lk, 1'b0});
            shiftKey <= sh;
            controlKey <= ct;
            expq.push_back(keyCode(k, sh, ct, lk));
            key(64'h1 << k, 0, 0, 0);
            drain;
        end
        expq.push_back(`KAE_CODE_DEL);
        key(0, 0, 1, 0);
        drain;
        shiftKey <= 1'b0;
        controlKey <= 1'b0;
        for (n = 0; n < 2; n++)
        begin
            wbXfer(`KAE_REG_CTRL, 1, 32'(n));
            expq.push_back(`KAE_CODE_CR);
            if (n == 1)
                expq.push_back(`KAE_CODE_LF);
            key(0, 1, 0, 0);
            drain;
        end
        for (n = 0; n < 4; n++)
        begin
            expq.push_back(`KAE_CODE_ESC);
            expq.push_back(`KAE_FUNC_BASE + 7'(n));
            key(0, 0, 0, 4'h1 << n);
            drain;
        end
        @(posedge mclk);
        keyLines <= 64'h3 << ($unsigned($random(seed)) % 63);
        wbXfer(`KAE_REG_STATUS, 0, 0);
        cmpWord(32'(rd[`KAE_ST_MULTI]), 32'h1);
        keyLines <= 64'h0;
        key(64'h1, 0, 1, 0);
        drain;
        @(posedge mclk);
        keyLines <= 64'h1 << 5;
        repeatKey <= 1'b1;
        repeat (3) expq.push_back(keyCode(5, 0, 0, 0));
        for (n = 0; n < 2; n++)
        begin
            repeat (20) @(posedge mclk);
            refFingerPass <= 1'b1;
            repeat (2) @(posedge mclk);
            refFingerPass <= 1'b0;
        end
        repeat (20) @(posedge mclk);
        keyLines <= 64'h0;
        repeatKey <= 1'b0;
        drain;
        interruptCond <= 1'b1;
        key(64'h1 << 9, 0, 0, 0);
        wbXfer(`KAE_REG_STATUS, 0, 0);
        cmpWord(32'(rd[1]), 32'h1);
        interruptCond <= 1'b0;
        drain;
        for (n = 0; n < 20; n++)
        begin
            ab[n] = 7'($random(seed));
            wbXfer(`KAE_REG_AB_BASE + 8'(4 * n), 1, {25'h0, ab[n]});
        end
        wbXfer(`KAE_REG_AB_BASE + 8'(4 * 7), 0, 0);
        cmpWord(rd, {25'h0, ab[7]});
        for (int t = 0; t < 5; t++)
        begin
            k = t * 6 + 1;
            wbXfer(`KAE_REG_CTRL, 1, {19'h0, 5'(k), 5'h0, (t != 3), 2'h0});
            case (t)
                0: answerbackButton <= 1'b1;
                1: enquiryRx <= 1'b1;
                2: delayedEnquiryFlag <= 1'b1;
                3: ringDetect <= 1'b1;
                default: wbXfer(`KAE_REG_TRIG, 1, 32'h1);
            endcase
            repeat (2) @(posedge mclk);
            {answerbackButton, enquiryRx, delayedEnquiryFlag, ringDetect} <= 4'h0;
            cmpWord(32'(kbdLockout), 32'h1);
            wbXfer(`KAE_REG_STATUS, 0, 0);
            cmpWord(32'(rd[1:0]), 32'h3);
            key(64'h1 << 12, 0, 0, 0);
            for (n = 0; n < ((t != 3 && k < 19) ? k + 1 : 20); n++)
                expq.push_back(ab[n]);
            drain;
        end
        finalReport;
    end
endmodule // kae_keyboard_encoder_bench
